// [logic/ccc_top.sv]
// Control and status pin logic of a multi-output clock generator
//
// Contract
// - Two-wire mode: shared pin is address LSB
// - Four/three-wire mode: shared pin is low-active select
// - Interrupt goes low on internal status change
// - Power-down low selects low power mode
// - Reset pin performs complete power-on reset
// - Reset forces visible registers to defaults
// - Clock outputs disabled throughout reset
// - Output-disable high turns off every output
// - Lock output high when locked, else low
// - Realign low resets all output dividers
// - Manual mode: input-select pins choose reference
// - Floating pins read their pull levels
// - Strap high two-wire, low four/three-wire
`timescale 1ns/1ps
`default_nettype none
`include "ccc_defs.svh"

module ccc_top #(
    parameter int NOUT       = `CCC_NUM_OUTPUTS,
    parameter int NSTAT      = `CCC_NUM_STATUS,
    parameter int RESET_HOLD = `CCC_RESET_HOLD_CYC
) (
    // Clock and power-up reset
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    // Control pins from the host
    input  wire logic             hard_reset_n_i,
    input  wire logic             powerdown_n_i,
    input  wire logic             output_disable_i,
    input  wire logic             divider_realign_n_i,
    input  wire logic [1:0]       in_sel_i,
    input  wire logic             addr_bit0_or_select_n_i,
    input  wire logic             serial_mode_strap_i,
    // Per-pin drive present; a clear bit means the pin floats
    input  wire logic [7:0]       pin_driven_i,
    // Internal configuration and status
    input  wire logic             manual_sel_mode_i,
    input  wire logic [1:0]       reg_ref_select_i,
    input  wire logic [NOUT-1:0]  out_config_en_i,
    input  wire logic             pll_locked_i,
    input  wire logic [NSTAT-1:0] status_event_i,
    input  wire logic [NSTAT-1:0] status_clear_i,
    // Status pins to the host
    output var  logic             irq_n_o,
    output var  logic             lock_indicator_o,
    // Clock output gating and divider control
    output var  logic [NOUT-1:0]  clk_out_enable_o,
    output var  logic             divider_reset_o,
    output var  logic             realign_done_o,
    output var  logic             low_power_o,
    // Reference selection
    output var  logic [1:0]       ref_select_o,
    // Serial interface front end
    output var  logic             serial_two_wire_o,
    output var  logic             bus_addr_lsb_o,
    output var  logic             spi_select_o,
    // Reset fan-out to the register file and core
    output var  logic             regs_default_o,
    output var  logic             reset_active_o,
    // Sticky status flags for readback
    output var  logic [NSTAT-1:0] status_flags_o
);

    import ccc_pkg::*;

    // ------------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------------
    logic [7:0] pin_raw;    // Levels as driven by the host
    logic [7:0] pin_level;  // Levels after internal pulls
    logic [7:0] pin_s;      // Synchronised, filtered levels

    // Gather pins in fixed positions
    always_comb begin
        pin_raw                          = '0;
        pin_raw[`CCC_PIN_HRST]           = hard_reset_n_i;
        pin_raw[`CCC_PIN_PDN]            = powerdown_n_i;
        pin_raw[`CCC_PIN_ODIS]           = output_disable_i;
        pin_raw[`CCC_PIN_REALIGN]        = divider_realign_n_i;
        pin_raw[`CCC_PIN_INSEL0 +: 2]    = in_sel_i;
        pin_raw[`CCC_PIN_ADDRSEL]        = addr_bit0_or_select_n_i;
        pin_raw[`CCC_PIN_STRAP]          = serial_mode_strap_i;
    end

    // An undriven pin takes its pull level
    assign pin_level = (pin_raw & pin_driven_i)
                     | (`CCC_PIN_PULL & ~pin_driven_i);

    // Every pin crosses in; the reset value is the pull level so a
    // floating pin never glitches the core at power-up
    ccc_sync #(
        .W         (`CCC_PIN_COUNT),
        .RESET_VAL (`CCC_PIN_PULL)
    ) u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .pin_i     (pin_level),
        .sync_o    (pin_s)
    );

    // Named views of the filtered pins
    logic       hard_reset_n_s;  // Host reset request, low active
    logic       powerdown_n_s;   // Power-down, low active
    logic       output_dis_s;    // Output disable, high active
    logic       realign_n_s;     // Divider realign, low active
    logic [1:0] in_sel_s;        // Manual reference choice
    logic       addr_sel_s;      // Shared address bit or select
    logic       strap_s;         // Serial mode strap

    assign hard_reset_n_s = pin_s[`CCC_PIN_HRST];
    assign powerdown_n_s  = pin_s[`CCC_PIN_PDN];
    assign output_dis_s   = pin_s[`CCC_PIN_ODIS];
    assign realign_n_s    = pin_s[`CCC_PIN_REALIGN];
    assign in_sel_s       = pin_s[`CCC_PIN_INSEL0 +: 2];
    assign addr_sel_s     = pin_s[`CCC_PIN_ADDRSEL];
    assign strap_s        = pin_s[`CCC_PIN_STRAP];

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    ccc_rst_state_t rst_state_q;  // Sequencer state
    logic [3:0]     hold_cnt_q;   // Cycles spent stretching
    logic           reset_active_q;

    // The pin acts through the synchroniser, so a pulse shorter than
    // a few clocks is filtered out; that is the price of clean release
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_state_q <= CCC_RST_ACTIVE;
            hold_cnt_q  <= 4'h0;
        end else if (!hard_reset_n_s) begin
            rst_state_q <= CCC_RST_ACTIVE;
            hold_cnt_q  <= 4'h0;
        end else begin
            unique case (rst_state_q)
                CCC_RST_ACTIVE: begin
                    rst_state_q <= CCC_RST_STRETCH;
                    hold_cnt_q  <= 4'h0;
                end
                CCC_RST_STRETCH: begin
                    // Hold a few cycles so the strap settles
                    if (hold_cnt_q == 4'(RESET_HOLD - 1)) begin
                        rst_state_q <= CCC_RST_RUN;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 4'h1;
                    end
                end
                CCC_RST_RUN: begin
                    rst_state_q <= CCC_RST_RUN;
                end
            endcase
        end
    end

    // Registered flag for everything the reset must hold off
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reset_active_q <= 1'b1;
        end else begin
            reset_active_q <= !hard_reset_n_s
                           || (rst_state_q != CCC_RST_RUN);
        end
    end

    // Register file clears to defaults while this stands
    assign regs_default_o = reset_active_q;
    assign reset_active_o = reset_active_q;

    // ------------------------------------------------------------------
    // Serial mode strap and shared pin
    // ------------------------------------------------------------------
    ccc_serial_mode_t mode_q;  // Mode frozen at reset release
    logic addr_lsb_q;          // Address LSB in two-wire mode
    logic spi_sel_q;           // Select asserted, four/three-wire

    // Strap is sampled by the clock on every reset cycle, so the
    // value seen just before release is the one that sticks
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q <= CCC_MODE_TWO_WIRE;
        end else if (reset_active_q) begin
            mode_q <= strap_s ? CCC_MODE_TWO_WIRE
                              : CCC_MODE_FOUR_THREE_WIRE;
        end
    end

    // Shared pin meaning depends on the mode
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            addr_lsb_q <= 1'b0;
            spi_sel_q  <= 1'b0;
        end else if (mode_q == CCC_MODE_TWO_WIRE) begin
            addr_lsb_q <= addr_sel_s;
            spi_sel_q  <= 1'b0;
        end else begin
            addr_lsb_q <= 1'b0;
            spi_sel_q  <= !addr_sel_s && !reset_active_q;
        end
    end

    assign serial_two_wire_o = (mode_q == CCC_MODE_TWO_WIRE);
    assign bus_addr_lsb_o    = addr_lsb_q;
    assign spi_select_o      = spi_sel_q;

    // ------------------------------------------------------------------
    // Power, output gating and divider realign
    // ------------------------------------------------------------------
    logic            low_power_q;   // Low power mode
    logic [NOUT-1:0] out_en_q;      // Per-output enable
    logic            div_reset_q;   // Divider reset level
    logic            realign_q;     // One-cycle release pulse

    // Power-down follows the pin level
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_power_q <= 1'b0;
        end else begin
            low_power_q <= !powerdown_n_s;
        end
    end

    // One gate per clock output
    genvar g;
    for (g = 0; g < NOUT; g++) begin : g_out
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                out_en_q[g] <= 1'b0;
            end else if (reset_active_q || rst_state_q != CCC_RST_RUN) begin
                out_en_q[g] <= 1'b0;
            end else if (output_dis_s) begin
                out_en_q[g] <= 1'b0;
            end else begin
                out_en_q[g] <= out_config_en_i[g] && powerdown_n_s;
            end
        end
    end

    // Dividers held while realign is low or the device is in reset
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_reset_q <= 1'b1;
            realign_q   <= 1'b0;
        end else begin
            div_reset_q <= !realign_n_s || reset_active_q;
            realign_q   <= div_reset_q && realign_n_s
                        && !reset_active_q;
        end
    end

    assign low_power_o      = low_power_q;
    assign clk_out_enable_o = out_en_q;
    assign divider_reset_o  = div_reset_q;
    assign realign_done_o   = realign_q;

    // ------------------------------------------------------------------
    // Reference selection and lock status
    // ------------------------------------------------------------------
    logic [1:0] ref_sel_q;  // Chosen reference input
    logic       lock_q;     // Lock indicator

    // Pins rule in manual mode, the register otherwise
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ref_sel_q <= `CCC_REF_SEL_RESET;
        end else if (reset_active_q) begin
            ref_sel_q <= `CCC_REF_SEL_RESET;
        end else if (manual_sel_mode_i) begin
            ref_sel_q <= in_sel_s;
        end else begin
            ref_sel_q <= reg_ref_select_i;
        end
    end

    // Reported as unlocked during reset
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= pll_locked_i && !reset_active_q;
        end
    end

    assign ref_select_o     = ref_sel_q;
    assign lock_indicator_o = lock_q;

    // ------------------------------------------------------------------
    // Sticky status and interrupt
    // ------------------------------------------------------------------
    ccc_sticky #(
        .N         (NSTAT)
    ) u_sticky (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .flush_i   (reset_active_q),
        .event_i   (status_event_i),
        .clear_i   (status_clear_i),
        .flags_o   (status_flags_o),
        .irq_n_o   (irq_n_o)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    // Release of the reset pin, then the stretch, then run
    sequence s_pin_release;
        $rose(hard_reset_n_s);
    endsequence
    sequence s_run_within;
        ##[1:12] !reset_active_q;
    endsequence

    a_reset_entry:    assert property (!hard_reset_n_s |=>
        reset_active_q [*2]) else $error("reset pin did not hold reset");
    a_reset_exit:     assert property (s_pin_release |-> s_run_within)
        else $error("reset did not release in time");
    a_reg_default:    assert property (!hard_reset_n_s |=>
        regs_default_o) else $error("registers not forced to default");
    a_clk_off_rst:    assert property (reset_active_q |=>
        clk_out_enable_o == '0) else $error("output live in reset");
    a_clk_off_odis:   assert property (output_dis_s |=>
        clk_out_enable_o == '0) else $error("output live when disabled");
    a_low_power:      assert property (!powerdown_n_s |=> low_power_o
        ##0 !$past(powerdown_n_s)) else $error("power-down ignored");
    a_lock_follow:    assert property (1'b1 |=> lock_indicator_o ==
        ($past(pll_locked_i) && !$past(reset_active_q)))
        else $error("lock output wrong");
    a_realign_hold:   assert property (!realign_n_s |=>
        divider_reset_o) else $error("dividers not held");
    a_realign_pulse:  assert property ($fell(divider_reset_o) |->
        realign_done_o)
        else $error("no realign pulse");
    a_irq_event:      assert property ((|status_event_i)
        && !reset_active_q |=> !irq_n_o) else $error("no interrupt on event");
    a_irq_sticky:     assert property (!irq_n_o
        && status_clear_i == '0 && status_event_i == '0 && !reset_active_q
        |=> !irq_n_o) else $error("interrupt dropped uncleared");
    a_addr_lsb:       assert property (serial_two_wire_o |=>
        bus_addr_lsb_o == $past(addr_sel_s)) else $error("bad addr lsb");
    a_spi_select:     assert property (!serial_two_wire_o
        && !addr_sel_s && !reset_active_q |=> spi_select_o)
        else $error("select not honoured");
    a_mode_frozen:    assert property (!reset_active_q
        && !$past(reset_active_q) |-> $stable(mode_q))
        else $error("mode changed while running");
    a_ref_manual:     assert property (manual_sel_mode_i
        && !reset_active_q |=> ref_select_o == $past(in_sel_s))
        else $error("manual reference not followed");
    a_float_insel:    assert property (
        (!pin_driven_i[`CCC_PIN_INSEL0] && !pin_driven_i[`CCC_PIN_INSEL1])
        [*6] |-> in_sel_s == 2'h0) else $error("floating select not low");

endmodule // ccc_top
`default_nettype wire

// [common/ccc_defs.svh]
// Constants for the clock chip control and status pin logic
`ifndef CCC_DEFS_SVH
`define CCC_DEFS_SVH

// ----------------------------------------------------------------------
// Pin vector bit positions
// ----------------------------------------------------------------------
`define CCC_PIN_HRST    0
`define CCC_PIN_PDN     1
`define CCC_PIN_ODIS    2
`define CCC_PIN_REALIGN 3
`define CCC_PIN_INSEL0  4
`define CCC_PIN_INSEL1  5
`define CCC_PIN_ADDRSEL 6
`define CCC_PIN_STRAP   7
`define CCC_PIN_COUNT   8

// ----------------------------------------------------------------------
// Levels read from each pin when nothing drives it
// ----------------------------------------------------------------------
// Bits 7..0: strap 1, addr/sel 1, in_sel 0 0, realign 1, odis 0, pdn 1, rst 1
`define CCC_PIN_PULL    8'hCB

// ----------------------------------------------------------------------
// Sizes and timing counts
// ----------------------------------------------------------------------
`define CCC_NUM_OUTPUTS     12
`define CCC_NUM_STATUS      8
`define CCC_RESET_HOLD_CYC  4
`define CCC_REF_SEL_RESET   2'h0

`endif

// [common/ccc_pkg.sv]
// Types shared by the clock chip control and status pin logic
package ccc_pkg;

    // ------------------------------------------------------------------
    // Serial interface mode, taken from the strap
    // ------------------------------------------------------------------
    typedef enum logic {
        CCC_MODE_TWO_WIRE,
        CCC_MODE_FOUR_THREE_WIRE
    } ccc_serial_mode_t;

    // ------------------------------------------------------------------
    // Internal reset sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CCC_RST_ACTIVE,
        CCC_RST_STRETCH,
        CCC_RST_RUN
    } ccc_rst_state_t;

endpackage : ccc_pkg

// [logic/ccc_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module ccc_sync #(
    parameter int         W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         reset_n_i,
    // Asynchronous pin levels
    input  wire logic [W-1:0] pin_i,
    // Filtered levels on clk_sys_i
    output var  logic [W-1:0] sync_o
);

    // ------------------------------------------------------------------
    // One chain per bit
    // ------------------------------------------------------------------
    genvar g;
    for (g = 0; g < W; g++) begin : g_bit
        logic ff1_q;  // Metastable stage, read only by ff2
        logic ff2_q;  // Second stage
        logic ff3_q;  // Third stage
        logic out_q;  // Accepted level

        // Shift chain; first stage feeds nothing but the second
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                ff1_q <= RESET_VAL[g];
                ff2_q <= RESET_VAL[g];
                ff3_q <= RESET_VAL[g];
            end else begin
                ff1_q <= pin_i[g];
                ff2_q <= ff1_q;
                ff3_q <= ff2_q;
            end
        end

        // A change counts only once stages two and three agree
        always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                out_q <= RESET_VAL[g];
            end else if (ff2_q == ff3_q) begin
                out_q <= ff3_q;
            end
        end

        assign sync_o[g] = out_q;
    end

endmodule // ccc_sync
`default_nettype wire

// [logic/ccc_sticky.sv]
// Sticky status flags and the active-low interrupt they raise
`timescale 1ns/1ps
`default_nettype none

module ccc_sticky #(
    parameter int N = 8
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         reset_n_i,
    // Synchronous flush while the device is held in reset
    input  wire logic         flush_i,
    // Status change events and software clears
    input  wire logic [N-1:0] event_i,
    input  wire logic [N-1:0] clear_i,
    // Flag state and interrupt
    output var  logic [N-1:0] flags_o,
    output var  logic         irq_n_o
);

    logic [N-1:0] flags_q;  // Sticky flags
    logic [N-1:0] flags_d;  // Next flag value
    logic         irq_n_q;  // Registered interrupt, low active

    // Set beats clear so an event in the clear cycle survives
    always_comb begin
        if (flush_i) begin
            flags_d = '0;
        end else begin
            flags_d = (flags_q & ~clear_i) | event_i;
        end
    end

    // Flag storage
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Interrupt low while any flag stands
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= ~(|flags_d);
        end
    end

    assign flags_o = flags_q;
    assign irq_n_o = irq_n_q;

endmodule // ccc_sticky
`default_nettype wire

// [verif/ccc_host_model.sv]
// Host-side model driving the control pins of the clock chip
`timescale 1ns/1ps
`default_nettype none

module ccc_host_model (
    // Clock
    input  wire logic       clk_sys_i,
    // Requested levels and drive flags
    input  wire logic [7:0] pin_req_i,
    input  wire logic [7:0] pin_drive_i,
    // Pins as the device sees them
    output var  logic [7:0] pins_o,
    output var  logic [7:0] pins_driven_o
);
    // -----------------------------------------------------------------
    // Pin drivers
    // -----------------------------------------------------------------
    initial pins_o = 8'h00;
    // Released pins keep toggling, so only the pull may decide them
    always @(posedge clk_sys_i) begin
        pins_driven_o <= pin_drive_i;
        // Strap, select and shared pin all driven the same way
        pins_o <= (pin_req_i & pin_drive_i) | (~pins_o & ~pin_drive_i);
    end
endmodule // ccc_host_model

`default_nettype wire

// [verif/ccc_top_tb.sv]
// Self-checking bench for the control and status pin logic
`timescale 1ns/1ps
`default_nettype none
`include "ccc_defs.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
    $display("FAIL %0t got %h exp %h", $time, a, e); end end

module ccc_top_tb;
    import ccc_pkg::*;
    // -----------------------------------------------------------------
    // Stimulus and observed signals
    // -----------------------------------------------------------------
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  req       = `CCC_PIN_PULL;  // Requested levels
    logic [7:0]  drv       = 8'h00;          // All pins float at start
    logic [7:0]  pins, pdrv, ev = 8'h00, clr = 8'h00, flg, evx;
    logic        manual = 1'b0, pll = 1'b0;
    logic [1:0]  rsel = 2'h0, ref_o;
    logic [11:0] cfg = 12'h000, en_o;
    logic        irq_n, lock, dres, rdone, lowp, two, alsb, ssel, rdef, ract;
    int          bad_count = 0, comparisons = 0;
    int unsigned seed = 27;
    logic        two_exp = 1'b1;  // Mode the strap should have latched

    always #50 clk_sys_i = ~clk_sys_i;

    ccc_host_model i_ccc_host_model (.clk_sys_i(clk_sys_i), .pin_req_i(req),
        .pin_drive_i(drv), .pins_o(pins), .pins_driven_o(pdrv));

    ccc_top i_ccc_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .hard_reset_n_i(pins[0]), .powerdown_n_i(pins[1]),
        .output_disable_i(pins[2]), .divider_realign_n_i(pins[3]),
        .in_sel_i(pins[5:4]), .addr_bit0_or_select_n_i(pins[6]),
        .serial_mode_strap_i(pins[7]), .pin_driven_i(pdrv),
        .manual_sel_mode_i(manual), .reg_ref_select_i(rsel),
        .out_config_en_i(cfg), .pll_locked_i(pll), .status_event_i(ev),
        .status_clear_i(clr), .irq_n_o(irq_n), .lock_indicator_o(lock),
        .clk_out_enable_o(en_o), .divider_reset_o(dres),
        .realign_done_o(rdone), .low_power_o(lowp), .ref_select_o(ref_o),
        .serial_two_wire_o(two), .bus_addr_lsb_o(alsb),
        .spi_select_o(ssel), .regs_default_o(rdef),
        .reset_active_o(ract), .status_flags_o(flg));

    // -----------------------------------------------------------------
    // Reference model and helpers
    // -----------------------------------------------------------------
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Compare settled outputs with levels worked out from pins and pulls
    task automatic check_all();
        logic [7:0] e;
        e = (req & drv) | (`CCC_PIN_PULL & ~drv);
        @(negedge clk_sys_i);
        `CHK(en_o, (e[1] && !e[2]) ? cfg : 12'h000)
        `CHK(lowp, ~e[1])
        `CHK(lock, pll)
        `CHK(dres, ~e[3])
        `CHK(ref_o, manual ? e[5:4] : rsel)
        `CHK(two, two_exp)
        `CHK(alsb, two_exp & e[6])
        `CHK(ssel, ~two_exp & ~e[6])
        `CHK(ract, 1'b0)
    endtask

    // Random pin and config mixes; hard reset pin stays high
    task automatic run_rand(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys_i);
            req[6:1] <= 6'(rnd());
            drv[6:0] <= 7'(rnd()) | 7'h01;
            req[0]   <= 1'b1;
            cfg      <= 12'(rnd());
            rsel     <= 2'(rnd());
            manual   <= 1'(rnd());
            pll      <= 1'(rnd());
            repeat (8) @(posedge clk_sys_i);
            check_all();
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys_i);
        `CHK(en_o, 12'h000)
        `CHK({irq_n, rdef, flg}, 10'h300)
        reset_n_i <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        check_all();
        run_rand(16);
        // Realign low holds the dividers; release gives one pulse
        @(posedge clk_sys_i) begin
            drv[3] <= 1'b1;
            req[3] <= 1'b0;
        end
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        `CHK({dres, rdone}, 2'h2)
        @(posedge clk_sys_i) req[3] <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        `CHK({dres, rdone}, 2'h1)
        @(negedge clk_sys_i);
        `CHK({dres, rdone}, 2'h0)
        // Event raises flag and interrupt, held until cleared
        evx = 8'(rnd()) | 8'h01;
        @(posedge clk_sys_i) ev <= evx;
        @(posedge clk_sys_i) ev <= 8'h00;
        @(negedge clk_sys_i);
        `CHK({irq_n, flg}, {1'b0, evx})
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        `CHK(irq_n, 1'b0)
        @(posedge clk_sys_i) clr <= evx;
        @(posedge clk_sys_i) clr <= 8'h00;
        @(negedge clk_sys_i);
        `CHK({irq_n, flg}, 9'h100)
        // Hard reset with strap low: flags dropped, new mode latched
        @(posedge clk_sys_i) ev <= 8'h05;
        @(posedge clk_sys_i) begin
            ev <= 8'h00;
            req[7] <= 1'b0;
            drv[7] <= 1'b1;
            req[0] <= 1'b0;
        end
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        `CHK({ract, en_o}, 13'h1000)
        `CHK({irq_n, rdef, flg}, 10'h300)
        @(posedge clk_sys_i) req[0] <= 1'b1;
        repeat (20) @(posedge clk_sys_i);
        two_exp = 1'b0;
        check_all();
        run_rand(16);
        close_out();
    end

    // Watchdog well beyond the expected run
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
endmodule // ccc_top_tb

`default_nettype wire
